// [rtl/dual_reload_timer_pwm.sv]
// top of the dual twelve-bit auto-reload pwm timer
// assumes a plain register port, read data one cycle after strobe
`timescale 1ns/1ns
`default_nettype none
`include "pwm_cfg.svh"
module dual_reload_timer_pwm #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // register port
  input  wire logic [3:0]       addr,
  input  wire logic [15:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [15:0]           rdata,
  // pins
  output logic [3:0]            waveform_outputs
);
  initial begin
    if (WIDTH != 12) $error("dual_reload_timer_pwm serves only twelve bits");
  end

  // ==========================================
  // register state
  logic             dual_counter_enable;   // dual mode
  logic             duty_transfer_one;
  logic             duty_transfer_two;
  logic             force_overflow_one;
  logic             force_overflow_two;
  logic [WIDTH-1:0] reload_value_one;
  logic [WIDTH-1:0] reload_value_two;
  logic [WIDTH-1:0] duty_preload [4];      // preloads per output
  logic [3:0]       polarity_bits;
  logic [3:0]       output_enable_bits;
  logic [15:0]      next_rdata;

  // next values
  logic             next_dual, next_tr_one, next_tr_two, next_f_one, next_f_two;
  logic [WIDTH-1:0] next_reload_one, next_reload_two;
  logic [WIDTH-1:0] next_duty [4];
  logic [3:0]       next_polarity, next_oe;

  // counters
  logic [WIDTH-1:0] count_one, counter_two;
  logic             ovf_one, ovf_two;

  // routing per output
  logic [3:0]       ch_ovf, ch_transfer;
  logic [WIDTH-1:0] ch_count [4];

  // decode a write to one address
  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  // ==========================================
  // counters
  reload_counter #(.WIDTH(WIDTH)) u_counter_one (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .reload         (reload_value_one),
    .force_req      (force_overflow_one),
    .count          (count_one),
    .overflow_event (ovf_one)
  );

  // counter two also runs in single mode; no pin uses it, but its overflow still clears force two
  reload_counter #(.WIDTH(WIDTH)) u_counter_two (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .reload         (reload_value_two),
    .force_req      (force_overflow_two),
    .count          (counter_two),
    .overflow_event (ovf_two)
  );

  // ==========================================
  // register writes and reads
  always_comb begin
    next_dual       = dual_counter_enable;
    next_tr_one     = duty_transfer_one;
    next_tr_two     = duty_transfer_two;
    next_reload_one = reload_value_one;
    next_reload_two = reload_value_two;
    next_polarity   = polarity_bits;
    next_oe         = output_enable_bits;
    for (int i = 0; i < 4; i++) begin
      next_duty[i] = duty_preload[i];
    end
    // hardware clears force once its overflow happened
    next_f_one = force_overflow_one & ~ovf_one;
    next_f_two = force_overflow_two & ~ovf_two;
    if (wr) begin
      if (hit(addr, `ADDR_CONTROL)) begin
        next_dual   = wdata[`BIT_DUAL];
        next_tr_one = wdata[`BIT_TRANSFER_ONE];
        next_tr_two = wdata[`BIT_TRANSFER_TWO];
        // software set wins over the hardware clear
        next_f_one  = next_f_one | wdata[`BIT_FORCE_ONE];
        next_f_two  = next_f_two | wdata[`BIT_FORCE_TWO];
      end
      if (hit(addr, `ADDR_RELOAD_ONE)) next_reload_one = wdata[WIDTH-1:0];
      if (hit(addr, `ADDR_RELOAD_TWO)) next_reload_two = wdata[WIDTH-1:0];
      for (int i = 0; i < 4; i++) begin
        if (hit(addr, `ADDR_DUTY_BASE + 4'(i))) next_duty[i] = wdata[WIDTH-1:0];
      end
      if (hit(addr, `ADDR_OUTPUT_CTRL)) begin
        next_oe       = wdata[3:0];
        next_polarity = wdata[7:4];
      end
    end
    // read data, unmapped reads zero
    next_rdata = 16'h0000;
    if (rd) begin
      case (addr)
        `ADDR_CONTROL:     next_rdata = {11'h000, force_overflow_two, force_overflow_one,
                                         duty_transfer_two, duty_transfer_one, dual_counter_enable};
        `ADDR_RELOAD_ONE:  next_rdata = {4'h0, reload_value_one};
        `ADDR_RELOAD_TWO:  next_rdata = {4'h0, reload_value_two};
        4'h4, 4'h5, 4'h6, 4'h7: next_rdata = {4'h0, duty_preload[addr[1:0]]};
        `ADDR_OUTPUT_CTRL: next_rdata = {8'h00, polarity_bits, output_enable_bits};
        `ADDR_STATUS:      next_rdata = {4'h0, count_one};
        default:           next_rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================
  // register update
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dual_counter_enable <= 1'b0;
      duty_transfer_one   <= 1'b1; // transfer set at reset
      duty_transfer_two   <= 1'b1;
      force_overflow_one  <= 1'b0;
      force_overflow_two  <= 1'b0;
      reload_value_one    <= `COUNT_ZERO;
      reload_value_two    <= `COUNT_ZERO;
      for (int i = 0; i < 4; i++) begin
        duty_preload[i] <= `COUNT_ZERO;
      end
      polarity_bits       <= 4'h0;
      output_enable_bits  <= 4'h0;
      rdata               <= 16'h0000;
    end else begin
      dual_counter_enable <= next_dual;
      duty_transfer_one   <= next_tr_one;
      duty_transfer_two   <= next_tr_two;
      force_overflow_one  <= next_f_one;
      force_overflow_two  <= next_f_two;
      reload_value_one    <= next_reload_one;
      reload_value_two    <= next_reload_two;
      for (int i = 0; i < 4; i++) begin
        duty_preload[i] <= next_duty[i];
      end
      polarity_bits       <= next_polarity;
      output_enable_bits  <= next_oe;
      rdata               <= next_rdata;
    end
  end

  // ==========================================
  // counter routing: outputs 2 and 3 follow counter two in dual mode
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dual_counter_enable && i >= 2) begin
        ch_ovf[i]      = ovf_two;
        ch_transfer[i] = duty_transfer_two;
        ch_count[i]    = counter_two;
      end else begin
        ch_ovf[i]      = ovf_one;
        ch_transfer[i] = duty_transfer_one;
        ch_count[i]    = count_one;
      end
    end
  end

  // ==========================================
  // channels
  for (genvar g = 0; g < 4; g++) begin : gen_channel
    pwm_channel #(.WIDTH(WIDTH)) u_channel (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .count          (ch_count[g]),
      .overflow_event (ch_ovf[g]),
      .transfer       (ch_transfer[g]),
      .duty_preload   (duty_preload[g]),
      .polarity       (polarity_bits[g]),
      .enable         (output_enable_bits[g]),
      .waveform       (waveform_outputs[g])
    );
  end
endmodule
`default_nettype wire

// [inc/pwm_cfg.svh]
// constants for the dual reload timer pwm block
// assumes a single 125 MHz clock and software on a plain register port
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ==========================================
// register offsets
`define ADDR_CONTROL      4'h0
`define ADDR_RELOAD_ONE   4'h1
`define ADDR_RELOAD_TWO   4'h2
`define ADDR_DUTY_BASE    4'h4
`define ADDR_OUTPUT_CTRL  4'h8
`define ADDR_STATUS       4'h9

// ==========================================
// control field positions
`define BIT_DUAL          0
`define BIT_TRANSFER_ONE  1
`define BIT_TRANSFER_TWO  2
`define BIT_FORCE_ONE     3
`define BIT_FORCE_TWO     4

// ==========================================
// reset values and timing
`define CONTROL_RESET     5'h06
`define OUTPUT_CTRL_RESET 8'h00
`define OVERFLOW_VALUE    12'hFFF
`define COUNT_ZERO        12'h000

`endif

// [inc/pwm_pkg.sv]
// types for the dual reload timer pwm block
// assumes pwm_cfg.svh supplies the numbers
package pwm_pkg;
  // overflow source of a counter
  typedef enum logic [1:0] {
    OVF_NONE    = 2'h0,
    OVF_NATURAL = 2'h1,
    OVF_FORCED  = 2'h3
  } overflow_kind_type;
endpackage

// [rtl/reload_counter.sv]
// one twelve-bit auto-reload up-counter with forced overflow
// assumes reload value and force request from the register side
`timescale 1ns/1ns
`default_nettype none
`include "pwm_cfg.svh"
module reload_counter #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // control
  input  wire logic [WIDTH-1:0] reload,
  input  wire logic             force_req,
  // state
  output logic [WIDTH-1:0]      count,
  output logic                  overflow_event
);
  initial begin
    if (WIDTH != 12) $error("reload_counter serves only twelve bits");
  end

  logic [WIDTH-1:0] next_count;     // next counter value
  logic             wrap;           // counter at top
  pwm_pkg::overflow_kind_type kind; // source of this overflow

  // ==========================================
  // next value: forced load to top, wrap to reload
  always_comb begin
    wrap = (count == WIDTH'(`OVERFLOW_VALUE));
    if (wrap) begin
      kind = force_req ? pwm_pkg::OVF_FORCED : pwm_pkg::OVF_NATURAL;
      next_count = reload;
    end else if (force_req) begin
      // jump straight to top; overflow follows next edge
      kind = pwm_pkg::OVF_NONE;
      next_count = WIDTH'(`OVERFLOW_VALUE);
    end else begin
      kind = pwm_pkg::OVF_NONE;
      next_count = count + WIDTH'(1);
    end
  end

  assign overflow_event = (kind != pwm_pkg::OVF_NONE);

  // ==========================================
  // register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= `COUNT_ZERO;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// [rtl/pwm_channel.sv]
// one pwm output: active duty, waveform, polarity flop, enable
// assumes overflow pulse and transfer bit of its counter
`timescale 1ns/1ns
`default_nettype none
`include "pwm_cfg.svh"
module pwm_channel #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // counter side
  input  wire logic [WIDTH-1:0] count,
  input  wire logic             overflow_event,
  input  wire logic             transfer,
  // software side
  input  wire logic [WIDTH-1:0] duty_preload,
  input  wire logic             polarity,
  input  wire logic             enable,
  // pin
  output logic                  waveform
);
  logic [WIDTH-1:0] active_duty;      // compared value
  logic [WIDTH-1:0] next_active_duty;
  logic             level;            // raw waveform
  logic             next_level;
  logic             polarity_flop;    // applied polarity
  logic             next_polarity_flop;
  logic             next_waveform;

  // ==========================================
  // next values
  always_comb begin
    next_active_duty   = active_duty;
    next_polarity_flop = polarity_flop;
    next_level         = level;
    if (overflow_event) begin
      next_level = 1'b1;
      if (transfer) begin
        next_active_duty   = duty_preload;
        next_polarity_flop = polarity;
      end
    end else if (count == active_duty) begin
      next_level = 1'b0;
    end
    // pin after inversion, gated by enable
    next_waveform = enable & (next_level ^ next_polarity_flop);
  end

  // ==========================================
  // registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active_duty   <= `COUNT_ZERO;
      level         <= 1'b0;
      polarity_flop <= 1'b0;
      waveform      <= 1'b0;
    end else begin
      active_duty   <= next_active_duty;
      level         <= next_level;
      polarity_flop <= next_polarity_flop;
      waveform      <= next_waveform;
    end
  end
endmodule
`default_nettype wire

// [tb/pwm_load_model.sv]
// load model on the four pwm pins: measures period and high time
// assumes pins are registered outputs of the timer on sys_clk
`timescale 1ns/1ns
`default_nettype none
module pwm_load_model (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // pins seen by the loads
  input  wire logic [3:0]       pins,
  // measured figures, updated at each edge of a pin
  output logic [3:0][12:0]      period,
  output logic [3:0][12:0]      high_len
);
  // ==========================================
  // measurement state
  logic [3:0][12:0] since;      // cycles since the last rise
  logic [3:0][12:0] hcnt;       // cycles high so far
  logic [3:0]       prev;       // pin level one cycle back
  // a load only listens; a stuck pin leaves the last figures standing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      since    <= '0;
      hcnt     <= '0;
      prev     <= 4'h0;
      period   <= '0;
      high_len <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        since[i] <= (pins[i] && !prev[i]) ? 13'h0001 : since[i] + 13'h0001;
        hcnt[i]  <= pins[i] ? (prev[i] ? hcnt[i] + 13'h0001 : 13'h0001) : 13'h0000;
        // rising edge closes one period
        if (pins[i] && !prev[i]) begin
          period[i] <= since[i];
        end
        // falling edge closes the high phase
        if (!pins[i] && prev[i]) begin
          high_len[i] <= hcnt[i];
        end
      end
      prev <= pins;
    end
  end
endmodule
`default_nettype wire

// [tb/dual_reload_timer_pwm_chk.sv]
// checker on the timer top ports: read port and pin timing
// assumes it is bound into the top; software writes are shadowed here
`timescale 1ns/1ns
`default_nettype none
`include "pwm_cfg.svh"
module dual_reload_timer_pwm_chk #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // register port
  input  wire logic [3:0]       addr,
  input  wire logic [15:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  input  wire logic [15:0]      rdata,
  // pins
  input  wire logic [3:0]       waveform_outputs
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // shadows of writes and pin0 period tracking
  logic [3:0]       oe_q, next_oe_q;       // enables as written
  logic [3:0]       pol_q, next_pol_q;     // polarity as written
  logic [WIDTH-1:0] rel1, next_rel1;       // reload one as written
  logic [WIDTH:0]   gap, next_gap;         // cycles since pin0 rose
  logic             quiet, next_quiet;     // no write since that rise
  logic             prev0;                 // pin0 one cycle back
  logic             rise0;
  assign rise0 = waveform_outputs[0] && !prev0;
  // any write may move edges, so it voids the next period check
  always_comb begin
    next_oe_q  = oe_q;
    next_pol_q = pol_q;
    next_rel1  = rel1;
    next_gap   = rise0 ? (WIDTH+1)'(1) : gap + (WIDTH+1)'(1);
    next_quiet = wr ? 1'b0 : (rise0 ? 1'b1 : quiet);
    if (wr && addr == `ADDR_OUTPUT_CTRL) begin
      next_oe_q  = wdata[3:0];
      next_pol_q = wdata[7:4];
    end
    if (wr && addr == `ADDR_RELOAD_ONE) begin
      next_rel1 = wdata[WIDTH-1:0];
    end
  end
  // registers only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_q  <= 4'h0;
      pol_q <= 4'h0;
      rel1  <= '0;
      gap   <= '0;
      quiet <= 1'b0;
      prev0 <= 1'b0;
    end else begin
      oe_q  <= next_oe_q;
      pol_q <= next_pol_q;
      rel1  <= next_rel1;
      gap   <= next_gap;
      quiet <= next_quiet;
      prev0 <= waveform_outputs[0];
    end
  end
  // ==========================================
  // assertions
  // force: flag set at the write edge, counter at top one edge later,
  // overflow and pin register one edge after that, seen sampled at ##3
  AST_RD_IDLE_ZERO: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_RD_UPPER_ZERO: assert property ($past(rd) |-> rdata[15:12] == 4'h0)
    else $error("read data upper bits not zero");
  AST_PINS_AFTER_RESET: assert property ($past(rst) |-> waveform_outputs == 4'h0)
    else $error("pins not low after reset");
  AST_OE_GATE: assert property (((~oe_q & ~$past(oe_q)) & waveform_outputs) == 4'h0)
    else $error("disabled pin is driven high");
  AST_PERIOD_ONE: assert property (rise0 && quiet |-> gap == ((WIDTH+1)'(1) << WIDTH) - {1'b0, rel1})
    else $error("pin0 period differs from counter span");
  AST_FORCE_ONE: assert property (wr && addr == `ADDR_CONTROL && wdata[`BIT_FORCE_ONE] && oe_q[0] && !pol_q[0]
    |-> ##3 waveform_outputs[0])
    else $error("forced overflow one did not raise pin0");
  AST_FORCE_TWO: assert property (wr && addr == `ADDR_CONTROL && wdata[`BIT_DUAL] && wdata[`BIT_FORCE_TWO]
    && oe_q[2] && !pol_q[2] |-> ##3 waveform_outputs[2])
    else $error("forced overflow two did not raise pin2");
  AST_COUNT_STEP: assert property (rd && addr == `ADDR_STATUS ##1 rd && addr == `ADDR_STATUS
    |=> rdata == $past(rdata) + 16'h0001 || rdata[WIDTH-1:0] == rel1 || rdata == 16'h0FFF)
    else $error("counter one did not step by one");
  // ==========================================
  // covers
  COV_PERIOD: cover property (rise0 && quiet);
  COV_FORCE: cover property (wr && addr == `ADDR_CONTROL && wdata[`BIT_FORCE_TWO]);
  COV_OE_OFF: cover property (oe_q == 4'h7);
endmodule
`default_nettype wire

// [tb/dual_reload_timer_pwm_tb_top.sv]
// top testbench: register tasks, pin load model, verdict
// assumes one 125 MHz clock; reset held for 12 cycles
`timescale 1ns/1ns
`default_nettype none
`include "pwm_cfg.svh"
module dual_reload_timer_pwm_tb_top;
  localparam int WIDTH = 12;
  // ==========================================
  // stimulus and observed signals
  logic             sys_clk = 1'b0;
  logic             rst     = 1'b1;
  logic [3:0]       addr    = 4'h0;
  logic [15:0]      wdata   = 16'h0000;
  logic             wr      = 1'b0;
  logic             rd      = 1'b0;
  logic [15:0]      rdata;
  logic [3:0]       waveform_outputs;
  logic [3:0][12:0] period, high_len;
  logic [15:0]      first, second;
  int               failures = 0;
  int               n_tests  = 0;
  // duty table; all above reload so every pin carries a wave
  logic [15:0]      duty [4] = '{16'h0FE0, 16'h0FD0, 16'h0FF0, 16'h0FE8};
  always #4 sys_clk = ~sys_clk;
  dual_reload_timer_pwm #(.WIDTH(WIDTH)) u_dual_reload_timer_pwm (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .waveform_outputs(waveform_outputs));
  pwm_load_model u_pwm_load_model (.sys_clk(sys_clk), .rst(rst), .pins(waveform_outputs), .period(period),
    .high_len(high_len));
  // ==========================================
  // tasks
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge sys_clk);
    rd <= 1'b1; addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 cmp(name, exp, rdata);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the sequence needs under 2000 cycles
  initial begin
    repeat (6000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd_reg(`ADDR_STATUS, 16'h0001, "count_start");
    rd_reg(`ADDR_CONTROL, 16'h0006, "control_reset");
    rd_reg(`ADDR_OUTPUT_CTRL, 16'h0000, "outctl_reset");
    rd_reg(4'h3, 16'h0000, "unmapped_3");
    rd_reg(4'hF, 16'h0000, "unmapped_f");
    wr_reg(`ADDR_RELOAD_ONE, 16'hFFC0);
    rd_reg(`ADDR_RELOAD_ONE, 16'h0FC0, "reload_one");
    wr_reg(`ADDR_OUTPUT_CTRL, 16'h000F);
    for (int i = 0; i < 4; i++) wr_reg(`ADDR_DUTY_BASE + 4'(i), duty[i]);
    wr_reg(`ADDR_CONTROL, 16'h000E);
    wait_cyc(200);
    for (int i = 0; i < 4; i++) begin
      cmp("period", 16'd64, {3'b000, period[i]});
      cmp("high", duty[i] - 16'h0FBF, {3'b000, high_len[i]});
    end
    rd_reg(`ADDR_CONTROL, 16'h0006, "force_one_clear");
    // two status reads back to back
    @(posedge sys_clk);
    rd <= 1'b1; addr <= `ADDR_STATUS;
    @(posedge sys_clk);
    #1 first = rdata;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 second = rdata;
    cmp("count_step", (first == 16'h0FFF) ? 16'h0FC0 : first + 16'h0001, second);
    // preload held while transfer one is off
    wr_reg(`ADDR_CONTROL, 16'h0004);
    wr_reg(`ADDR_DUTY_BASE, 16'h0FF0);
    wait_cyc(200);
    cmp("high_held", 16'h0021, {3'b000, high_len[0]});
    wr_reg(`ADDR_CONTROL, 16'h0006);
    wr_reg(`ADDR_CONTROL, 16'h0006);
    wait_cyc(200);
    cmp("high_moved", 16'h0031, {3'b000, high_len[0]});
    // dual mode, counter two forced
    wr_reg(`ADDR_RELOAD_TWO, 16'h0FE0);
    wr_reg(`ADDR_CONTROL, 16'h0017);
    wait_cyc(200);
    cmp("period0", 16'd64, {3'b000, period[0]});
    cmp("period2", 16'd32, {3'b000, period[2]});
    cmp("period3", 16'd32, {3'b000, period[3]});
    cmp("high2", 16'h0011, {3'b000, high_len[2]});
    rd_reg(`ADDR_CONTROL, 16'h0007, "force_two_clear");
    // invert pin3, then disable it
    wr_reg(`ADDR_OUTPUT_CTRL, 16'h008F);
    wait_cyc(200);
    cmp("high3_inv", 16'h0017, {3'b000, high_len[3]});
    wr_reg(`ADDR_OUTPUT_CTRL, 16'h0087);
    wait_cyc(40);
    cmp("pin3_off", 16'h0000, {15'h0000, waveform_outputs[3]});
    wrap_up();
  end
endmodule
bind dual_reload_timer_pwm dual_reload_timer_pwm_chk #(.WIDTH(WIDTH)) u_dual_reload_timer_pwm_chk (
  .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .waveform_outputs(waveform_outputs));
`default_nettype wire
